// ### design/discharge_pkg.sv
/*
 * Shared constants and carriers for the regulator output discharge control bank.
 * Assumes a 32-bit APB master and the 40 MHz system clock.
 */
package discharge_pkg;

    localparam int unsigned NUM_REGULATORS = 8;
    localparam int unsigned APB_ADDR_W     = 12;
    localparam int unsigned APB_DATA_W     = 32;

    // register indices; the byte address is four times the index
    localparam logic [7:0] DISCHARGE_LOW_INDEX   = 8'h2d;
    localparam logic [7:0] DISCHARGE_STATE_INDEX = 8'h30;
    localparam logic [7:0] OTP_DEFAULT_INDEX     = 8'h31;

    localparam logic [APB_ADDR_W-1:0] DISCHARGE_LOW_ADDR   = {2'b00, DISCHARGE_LOW_INDEX, 2'b00};
    localparam logic [APB_ADDR_W-1:0] DISCHARGE_STATE_ADDR = {2'b00, DISCHARGE_STATE_INDEX, 2'b00};
    localparam logic [APB_ADDR_W-1:0] OTP_DEFAULT_ADDR     = {2'b00, OTP_DEFAULT_INDEX, 2'b00};

    // field positions inside regulator_output_discharge_enable_low
    localparam int unsigned REG8_BIT = 7;
    localparam int unsigned REG7_BIT = 6;
    localparam int unsigned REG6_BIT = 5;
    localparam int unsigned REG5_BIT = 4;
    localparam int unsigned REG4_BIT = 3;
    localparam int unsigned REG3_BIT = 2;
    localparam int unsigned REG2_BIT = 1;
    localparam int unsigned REG1_BIT = 0;

    localparam logic [APB_DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [APB_ADDR_W-1:0] paddr;
        logic [APB_DATA_W-1:0] pwdata;
    } apb_req_t;

    // bit order matches the register: reg8 at bit 7 down to reg1 at bit 0
    typedef struct packed {
        logic reg8_pulldown_on_disable;
        logic reg7_pulldown_on_disable;
        logic reg6_pulldown_on_disable;
        logic reg5_pulldown_on_disable;
        logic reg4_pulldown_on_disable;
        logic reg3_pulldown_on_disable;
        logic reg2_pulldown_on_disable;
        logic reg1_pulldown_on_disable;
    } discharge_ctrl_t;

endpackage

// ### design/discharge_gate.sv
/*
 * One regulator's discharge request: pull the output down while the
 * regulator is off and its enable bit is set.
 * Assumes the regulator enable comes from logic on sys_clk.
 */
`timescale 1ns/1ps
module discharge_gate (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic pulldown_on_disable,
    input  wire logic regulator_enabled,
    output logic      discharge_on
);

    logic discharge_reg;
    logic discharge_next;

    // request is registered, so it follows a regulator enable change one cycle late
    always_comb begin
        discharge_next = pulldown_on_disable & ~regulator_enabled;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            discharge_reg <= 1'b0;
        end else begin
            discharge_reg <= discharge_next;
        end
    end

    assign discharge_on = discharge_reg;

endmodule

// ### design/regulator_discharge_control.sv
/*
 * APB register bank holding the per-regulator output discharge enables for
 * regulators 1 to 8, and the discharge requests sent to the analog switches.
 * Assumes an APB master on sys_clk, OTP defaults stable around reset and
 * regulator enables produced on sys_clk.
 */
// Our own choice: the APB register port.
//
// Behaviour
// RULE1: bit 7 set discharges regulator 8 while disabled; clear means no discharge.
// RULE2: bit 6 set discharges regulator 7 while disabled; clear means no discharge.
// RULE3: bits 5, 4, 0 do the same for regulators 6, 5, 1.
// RULE4: bit 3 set discharges regulator 4 while disabled; clear means no discharge.
// RULE5: bit 2 set discharges regulator 3 while disabled; clear means no discharge.
// RULE6: bit 1 set discharges regulator 2 while disabled; clear means no discharge.
// RULE7: reset loads all bits from OTP defaults; software may then read and write.
`timescale 1ns/1ps
module regulator_discharge_control
    import discharge_pkg::*;
#(
    parameter int unsigned N_REG = NUM_REGULATORS
) (
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire apb_req_t               apb_req,
    output logic [APB_DATA_W-1:0]       prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [N_REG-1:0]       otp_default,
    input  wire logic [N_REG-1:0]       regulator_enabled,
    output discharge_ctrl_t             discharge_ctrl,
    output logic [N_REG-1:0]            discharge_on
);

    logic [N_REG-1:0]      ctrl_reg;
    logic [N_REG-1:0]      ctrl_next;
    logic [N_REG-1:0]      otp_seen_reg;
    logic [N_REG-1:0]      otp_seen_next;
    logic [APB_DATA_W-1:0] rdata_reg;
    logic [APB_DATA_W-1:0] rdata_next;
    logic                  setup_phase;
    logic                  access_phase;
    logic                  hit_ctrl;
    logic                  hit_state;
    logic                  hit_otp;
    logic                  mapped;

    // address decode; low two byte-address bits must be zero for a hit
    always_comb begin
        hit_ctrl  = (apb_req.paddr == DISCHARGE_LOW_ADDR);
        hit_state = (apb_req.paddr == DISCHARGE_STATE_ADDR);
        hit_otp   = (apb_req.paddr == OTP_DEFAULT_ADDR);
        mapped    = hit_ctrl | hit_state | hit_otp;
    end

    assign setup_phase  = apb_req.psel & ~apb_req.penable;
    assign access_phase = apb_req.psel & apb_req.penable;

    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    // status registers are read only, so writing them errors too
    assign pslverr = access_phase & (~mapped | (apb_req.pwrite & ~hit_ctrl));

    // control bits: OTP default on reset, software writes afterwards
    always_comb begin
        ctrl_next     = ctrl_reg;
        otp_seen_next = otp_seen_reg;
        if (reset) begin
            ctrl_next     = otp_default; // RULE7
            otp_seen_next = otp_default;
        end else if (access_phase && apb_req.pwrite && hit_ctrl) begin
            ctrl_next = apb_req.pwdata[N_REG-1:0]; // RULE7
        end
    end

    // synchronous reset lets the strap value be loaded by the clocked process
    always_ff @(posedge sys_clk) begin
        ctrl_reg     <= ctrl_next;
        otp_seen_reg <= otp_seen_next;
    end

    // read data captured in setup so it comes from a flip-flop in access
    always_comb begin
        rdata_next = rdata_reg;
        if (reset) begin
            rdata_next = READ_ZERO;
        end else if (setup_phase && !apb_req.pwrite) begin
            rdata_next = READ_ZERO;
            if (hit_ctrl) begin
                rdata_next[N_REG-1:0] = ctrl_reg; // RULE7
            end else if (hit_state) begin
                rdata_next[N_REG-1:0] = discharge_on;
            end else if (hit_otp) begin
                rdata_next[N_REG-1:0] = otp_seen_reg;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        rdata_reg <= rdata_next;
    end

    assign prdata = rdata_reg;

    // named view of the control bits for the analog side
    always_comb begin
        discharge_ctrl                          = '0;
        discharge_ctrl.reg8_pulldown_on_disable = ctrl_reg[REG8_BIT]; // RULE1
        discharge_ctrl.reg7_pulldown_on_disable = ctrl_reg[REG7_BIT]; // RULE2
        discharge_ctrl.reg6_pulldown_on_disable = ctrl_reg[REG6_BIT]; // RULE3
        discharge_ctrl.reg5_pulldown_on_disable = ctrl_reg[REG5_BIT]; // RULE3
        discharge_ctrl.reg4_pulldown_on_disable = ctrl_reg[REG4_BIT]; // RULE4
        discharge_ctrl.reg3_pulldown_on_disable = ctrl_reg[REG3_BIT]; // RULE5
        discharge_ctrl.reg2_pulldown_on_disable = ctrl_reg[REG2_BIT]; // RULE6
        discharge_ctrl.reg1_pulldown_on_disable = ctrl_reg[REG1_BIT]; // RULE3
    end

    // bit i drives the discharge switch of regulator i+1
    genvar i;
    generate
        for (i = 0; i < N_REG; i++) begin : g_gate
            discharge_gate u_gate (
                .sys_clk             (sys_clk),
                .reset               (reset),
                .pulldown_on_disable (ctrl_reg[i]),
                .regulator_enabled   (regulator_enabled[i]),
                .discharge_on        (discharge_on[i])
            ); // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6
        end
    endgenerate

endmodule

// ### verif/discharge_props.sv
/* assertions on the discharge bank ports
   bound into regulator_discharge_control, one clock */
`timescale 1ns/1ps
module discharge_props
    import discharge_pkg::*;
#(parameter int unsigned N_REG = NUM_REGULATORS) (
    input wire logic                  sys_clk,
    input wire logic                  reset,
    input wire apb_req_t              apb_req,
    input wire logic [APB_DATA_W-1:0] prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [N_REG-1:0]      otp_default,
    input wire logic [N_REG-1:0]      regulator_enabled,
    input wire discharge_ctrl_t       discharge_ctrl,
    input wire logic [N_REG-1:0]      discharge_on
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence wr_s;
        apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == DISCHARGE_LOW_ADDR;
    endsequence
    // skip the edge after reset, where the request was forced low
    property dis_p(int b);
        !$past(reset) |-> discharge_on[b] == $past(discharge_ctrl[b] & ~regulator_enabled[b]);
    endproperty
    reg8_dis_a: assert property (dis_p(7)) else $error("reg8 discharge wrong");
    reg7_dis_a: assert property (dis_p(6)) else $error("reg7 discharge wrong");
    reg6_dis_a: assert property (dis_p(5)) else $error("reg6 discharge wrong");
    reg1_dis_a: assert property (dis_p(0)) else $error("reg1 discharge wrong");
    reg4_dis_a: assert property (dis_p(3)) else $error("reg4 discharge wrong");
    reg3_dis_a: assert property (dis_p(2)) else $error("reg3 discharge wrong");
    reg2_dis_a: assert property (dis_p(1)) else $error("reg2 discharge wrong");
    otp_load_a: assert property ($past(reset) |-> discharge_ctrl == $past(otp_default))
        else $error("reset default not loaded");
    sw_write_a: assert property (wr_s |=> discharge_ctrl == $past(apb_req.pwdata[7:0]))
        else $error("write not taken");
endmodule
bind regulator_discharge_control discharge_props #(.N_REG(N_REG)) i_props (.sys_clk, .reset,
    .apb_req, .prdata, .pready, .pslverr, .otp_default, .regulator_enabled, .discharge_ctrl,
    .discharge_on);

// ### verif/regulator_discharge_control_tb.sv
/* self-checking bench for the discharge bank
   drives APB, OTP defaults and regulator enables directly */
`timescale 1ns/1ps
module regulator_discharge_control_tb;
    import discharge_pkg::*;
    logic            sys_clk;
    logic            reset;
    apb_req_t        apb_req;
    logic [31:0]     prdata;
    logic [31:0]     rd;
    logic            pready;
    logic            pslverr;
    logic            er;
    logic [7:0]      otp_default;
    logic [7:0]      regulator_enabled;
    logic [7:0]      discharge_on;
    logic [7:0]      c;
    discharge_ctrl_t discharge_ctrl;
    int              n_errors = 0;
    int              compares = 0;
    int              seed = 4806;
    int              cyc = 0;
    regulator_discharge_control i_regulator_discharge_control (.sys_clk, .reset, .apb_req,
        .prdata, .pready, .pslverr, .otp_default, .regulator_enabled, .discharge_ctrl,
        .discharge_on);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    function automatic logic [7:0] dis(input logic [7:0] k, input logic [7:0] e);
        return k & ~e;
    endfunction
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    task automatic do_reset(input logic [7:0] o);
        otp_default <= o;
        reset <= 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        c = o;
        apb(1'b0, DISCHARGE_LOW_ADDR, 32'h0000_0000);
        chk("otp default", {24'h0000_00, c}, rd);
    endtask
    initial begin
        reset = 1'b1;
        apb_req = '0;
        regulator_enabled = 8'h00;
        otp_default = 8'h00;
        do_reset(8'h60);
        // walking one, all ones, random data with all enables set, then random data and enables
        for (int i = 0; i < 40; i++) begin
            c = i < 8 ? 8'h01 << i : (i == 8 ? 8'hff : 8'($random(seed)));
            regulator_enabled <= i < 9 ? 8'h00 : (i == 9 ? 8'hff : 8'($random(seed)));
            apb(1'b1, DISCHARGE_LOW_ADDR, {24'($random(seed)), c});
            repeat (2) @(posedge sys_clk);
            #1;
            chk("discharge", dis(c, regulator_enabled), discharge_on);
            apb(1'b0, DISCHARGE_LOW_ADDR, 32'h0000_0000);
            chk("readback", {24'h0000_00, c}, rd);
            chk("ready", 32'h0000_0001, {31'h0, pready});
        end
        // status views: live discharge requests and the latched defaults
        apb(1'b0, DISCHARGE_STATE_ADDR, 32'h0000_0000);
        chk("state read", {24'h0000_00, dis(c, regulator_enabled)}, rd);
        chk("state error", 32'h0000_0000, {31'h0, er});
        apb(1'b0, OTP_DEFAULT_ADDR, 32'h0000_0000);
        chk("otp read", 32'h0000_0060, rd);
        // read-only place must refuse and leave the bits alone
        apb(1'b1, DISCHARGE_STATE_ADDR, 32'h0000_00ff);
        chk("ro error", 32'h0000_0001, {31'h0, er});
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, er});
        chk("unmapped data", 32'h0000_0000, rd);
        apb(1'b0, DISCHARGE_LOW_ADDR, 32'h0000_0000);
        chk("after refusal", {24'h0000_00, c}, rd);
        do_reset(8'($random(seed)));
        apb(1'b0, OTP_DEFAULT_ADDR, 32'h0000_0000);
        chk("otp read after reset", {24'h0000_00, c}, rd);
        tally_and_finish;
    end
endmodule
